/* rtl/dmc_regs.sv */
/*
 APB register bank that builds and issues DRAM mode-register commands
 and reports calibration and 3DS refresh status.
 Assumes the memory sequencer takes mr_valid/mr_* as a one-cycle
 request and that status inputs are synchronous to pclk.
*/
// What this block does
// - Command kind in bits 2:0; only 000 (mode register set) is valid.
// - Chip-select field bits 6:3 picks target chip selects, one bit each.
// - Mode register set goes to every chip select whose bit is set.
// - LPDDR3 payload: falling CA 9:0 at 19:10, rising CA 9:4 at 9:4.
// - LPDDR3 write: operand at 19:12, register address at 11:4.
// - DDR4 payload: C at 26:24, ACT 23, BG 22:21, BA 19:18, A 17:0.
// - DDR3 payload: BA 20:18, A14 at 17, pins 16:14, A 13:0.
// - Read-only bits 3:1 show the current DDR4 3DS refresh chip ID.
// - Calibration-success status bit 0 reads one after passing.
// - Calibration-fail status bit 1 reads one after failing.
// - Refresh acknowledge vector: one byte per physical rank, 0 to 3.
// - In-progress flag stays high while a mode command executes.
`timescale 1ns/1ps
module dmc_regs (
   // Clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [11:0]                    paddr,
   input  wire logic [31:0]                    pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Status from PHY and controller
   input  wire logic                           cal_success,
   input  wire logic                           cal_fail,
   input  wire logic [2:0]                     stacked_refresh_cid_in,
   input  wire logic [31:0]                    stacked_refresh_ack_in,
   input  wire logic [dmc_pkg::DMC_INFO_W-1:0] interface_width_in,
   input  wire logic [dmc_pkg::DMC_INFO_W-1:0] toolchain_version_in,
   // Command to memory sequencer
   output logic                                mr_valid,
   output logic      [dmc_pkg::DMC_CS_W-1:0]   mr_chip_selects,
   output logic      [31:0]                    mr_payload,
   input  wire logic                           mr_done
);
   import dmc_pkg::*;

   // Only kind and chip-select bits exist in the control word
   logic [DMC_CS_HI:0]  ctrl_reg;
   logic [31:0]         payload_reg;
   dmc_proto_t          proto_reg;
   dmc_state_t          state_reg;
   logic [3:0]          hold_reg;
   logic                cal_ok_reg;
   logic                cal_fail_reg;
   logic [2:0]          cid_reg;
   logic [31:0]         ack_reg;
   logic                rejected_reg;

   logic                wr_en;
   logic                rd_en;
   logic [9:0]          word_idx;
   logic                issue_req;
   logic                cmd_accept;
   logic [31:0]         wr_mask;
   logic [31:0]         prdata_next;
   logic                hit;

   // Expand byte strobes into a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   // Clear reserved payload bits for the selected protocol
   function automatic logic [31:0] pay_mask(input dmc_proto_t p);
      logic [31:0] m;
      m = DMC_MASK_DDR3;
      if (p == DMC_PROTO_DDR4) begin
         m = DMC_MASK_DDR4;
      end else if (p == DMC_PROTO_LPDDR3) begin
         m = DMC_MASK_LPDDR3;
      end
      return m;
   endfunction

   // Only the set kind with at least one target may reach the pins
   function automatic logic cmd_legal(input logic [DMC_CS_HI:0] c);
      logic ok;
      ok = (c[DMC_KIND_HI:DMC_KIND_LO] == DMC_KIND_MRS)
           && (c[DMC_CS_HI:DMC_CS_LO] != 4'h0);
      return ok;
   endfunction

   // Zero wait states: every access phase completes at once
   assign pready   = 1'b1;
   assign word_idx = paddr[11:2];
   assign wr_en    = psel && penable && pwrite;
   assign rd_en    = psel && !penable && !pwrite;
   assign issue_req = wr_en && (word_idx == 10'(DMC_IDX_ISSUE))
                      && pstrb[0] && pwdata[0];
   assign wr_mask  = strb_mask(pstrb);
   // Busy or malformed issues never start a command
   assign cmd_accept = issue_req && (state_reg == DMC_IDLE)
                       && cmd_legal(ctrl_reg);

   // Control word: kind and chip selects are the only stored bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
      end else if (wr_en && word_idx == 10'(DMC_IDX_CTRL)) begin
         ctrl_reg <= (ctrl_reg & ~wr_mask[DMC_CS_HI:DMC_KIND_LO])
                     | (pwdata[DMC_CS_HI:DMC_KIND_LO]
                        & wr_mask[DMC_CS_HI:DMC_KIND_LO]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         payload_reg <= 32'h0;
      end else if (wr_en && word_idx == 10'(DMC_IDX_PAYLOAD)) begin
         payload_reg <= (payload_reg & ~strb_mask(pstrb))
                        | (pwdata & strb_mask(pstrb));
      end
   end

   // Protocol select decides which payload bits are reserved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         proto_reg <= DMC_PROTO_DDR3;
      end else if (wr_en && word_idx == 10'(DMC_IDX_PROTO) && pstrb[0]) begin
         if (pwdata[1:0] != 2'b11) begin
            proto_reg <= dmc_proto_t'(pwdata[1:0]);
         end
      end
   end

   // Command sequencer: drive one cycle, then hold busy until done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= DMC_IDLE;
      end else begin
         case (state_reg)
            DMC_IDLE: begin
               if (cmd_accept) begin
                  state_reg <= DMC_DRIVE;
               end
            end
            DMC_DRIVE: begin
               state_reg <= DMC_WAIT;
            end
            DMC_WAIT: begin
               // Done is ignored until the minimum busy time has passed,
               // so a sequencer that is slow to drop done cannot cut it
               if (hold_reg == 4'h0 && mr_done) begin
                  state_reg <= DMC_IDLE;
               end
            end
            default: begin
               state_reg <= DMC_IDLE;
            end
         endcase
      end
   end

   // Minimum busy time counts down only while waiting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 4'h0;
      end else if (cmd_accept) begin
         hold_reg <= DMC_CMD_CYCLES;
      end else if (state_reg == DMC_WAIT && hold_reg != 4'h0) begin
         hold_reg <= hold_reg - 4'h1;
      end
   end

   // One-cycle request pulse to the memory sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mr_valid <= 1'b0;
      end else begin
         mr_valid <= cmd_accept;
      end
   end

   // Fields stand from the request until the next accepted issue
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mr_chip_selects <= 4'h0;
         mr_payload      <= 32'h0;
      end else if (cmd_accept) begin
         mr_chip_selects <= ctrl_reg[DMC_CS_HI:DMC_CS_LO];
         // Reserved bits are cleared so the pins never carry stale junk
         mr_payload      <= payload_reg & pay_mask(proto_reg);
      end
   end

   // Records whether the last issue was refused while busy or malformed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rejected_reg <= 1'b0;
      end else if (issue_req) begin
         rejected_reg <= !cmd_accept;
      end
   end

   // Calibration flags stay set once seen; only reset clears them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_ok_reg <= 1'b0;
      end else if (cal_success) begin
         cal_ok_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_fail_reg <= 1'b0;
      end else if (cal_fail) begin
         cal_fail_reg <= 1'b1;
      end
   end

   // Refresh status is a one-cycle copy of the controller's view
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cid_reg <= 3'h0;
         ack_reg <= 32'h0;
      end else begin
         cid_reg <= stacked_refresh_cid_in;
         ack_reg <= stacked_refresh_ack_in;
      end
   end

   // Read decode
   always_comb begin
      prdata_next = 32'h0;
      hit         = 1'b1;
      if (word_idx == 10'(DMC_IDX_CTRL)) begin
         prdata_next[DMC_CS_HI:DMC_KIND_LO] = ctrl_reg[DMC_CS_HI:DMC_KIND_LO];
      end else if (word_idx == 10'(DMC_IDX_PAYLOAD)) begin
         prdata_next = payload_reg;
      end else if (word_idx == 10'(DMC_IDX_CID)) begin
         prdata_next[DMC_CID_HI:DMC_CID_LO] = cid_reg;
      end else if (word_idx == 10'(DMC_IDX_CAL)) begin
         prdata_next[DMC_CAL_OK]   = cal_ok_reg;
         prdata_next[DMC_CAL_FAIL] = cal_fail_reg;
      end else if (word_idx == 10'(DMC_IDX_WIDTH)) begin
         prdata_next[DMC_INFO_W-1:0] = interface_width_in;
      end else if (word_idx == 10'(DMC_IDX_VERSION)) begin
         prdata_next[DMC_INFO_W-1:0] = toolchain_version_in;
      end else if (word_idx == 10'(DMC_IDX_ACK)) begin
         prdata_next = ack_reg;
      end else if (word_idx == 10'(DMC_IDX_PROGRESS)) begin
         prdata_next[0] = (state_reg != DMC_IDLE);
         prdata_next[1] = rejected_reg;
      end else if (word_idx == 10'(DMC_IDX_PROTO)) begin
         prdata_next[1:0] = proto_reg;
      end else if (word_idx == 10'(DMC_IDX_ISSUE)) begin
         prdata_next = 32'h0;
      end else begin
         hit = 1'b0;
      end
   end

   // Read data latched in setup so it is a flop during access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         prdata <= prdata_next;
      end
   end

   // Unmapped addresses answer with an error in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !hit;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end
endmodule

/* rtl/dmc_pkg.sv */
/*
 Constants for the DRAM mode-command and status register bank:
 word indices, field positions, payload masks, command codes.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package dmc_pkg;
   // Printed offsets are word indices; byte address is four times that
   localparam logic [7:0] DMC_IDX_CTRL     = 8'h37;
   localparam logic [7:0] DMC_IDX_PAYLOAD  = 8'h38;
   localparam logic [7:0] DMC_IDX_CID      = 8'h39;
   localparam logic [7:0] DMC_IDX_CAL      = 8'h3b;
   localparam logic [7:0] DMC_IDX_WIDTH    = 8'h44;
   localparam logic [7:0] DMC_IDX_VERSION  = 8'h45;
   localparam logic [7:0] DMC_IDX_ACK      = 8'h4f;
   localparam logic [7:0] DMC_IDX_PROGRESS = 8'h31;
   localparam logic [7:0] DMC_IDX_ISSUE    = 8'h60;
   localparam logic [7:0] DMC_IDX_PROTO    = 8'h61;

   localparam int DMC_KIND_LO  = 0;
   localparam int DMC_KIND_HI  = 2;
   localparam int DMC_CS_LO    = 3;
   localparam int DMC_CS_HI    = 6;
   localparam int DMC_CS_W     = 4;
   localparam int DMC_CID_LO   = 1;
   localparam int DMC_CID_HI   = 3;
   localparam int DMC_CAL_OK   = 0;
   localparam int DMC_CAL_FAIL = 1;
   localparam int DMC_INFO_W   = 16;

   localparam logic [2:0] DMC_KIND_MRS = 3'h0;

   // Payload masks per protocol: reserved bits are forced to zero
   localparam logic [31:0] DMC_MASK_LPDDR3 = 32'h000ffff0;
   localparam logic [31:0] DMC_MASK_DDR4   = 32'h07efffff;
   localparam logic [31:0] DMC_MASK_DDR3   = 32'h001fffff;

   // Cycles the command is held busy on the memory side
   localparam int          DMC_CMD_TIME_NS  = 200;
   localparam int          DMC_CLK_NS       = 40;
   localparam logic [3:0]  DMC_CMD_CYCLES   =
      4'((DMC_CMD_TIME_NS + DMC_CLK_NS - 1) / DMC_CLK_NS);

   typedef enum logic [1:0] {
      DMC_PROTO_DDR3   = 2'b00,
      DMC_PROTO_DDR4   = 2'b01,
      DMC_PROTO_LPDDR3 = 2'b10
   } dmc_proto_t;

   typedef enum logic [1:0] {
      DMC_IDLE  = 2'b00,
      DMC_DRIVE = 2'b01,
      DMC_WAIT  = 2'b10
   } dmc_state_t;
endpackage

/* dv/dmc_regs_props.sv */
/*
 Checker for the mode-command register bank, seeing top ports only.
 Assumes zero-wait APB with read data loaded in the setup cycle.
*/
`timescale 1ns/1ps
module dmc_regs_props (
   // Clock, reset, bus and status
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata, stacked_refresh_ack_in,
   input wire logic        cal_success,
   input wire logic [2:0]  stacked_refresh_cid_in,
   // Command side
   input wire logic        mr_valid,
   input wire logic [3:0]  mr_chip_selects,
   input wire logic [31:0] mr_payload
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence s_sent;
      mr_valid ##[1:6] s_rd(12'h0c4);
   endsequence
   a_issue_cause: assert property (
      mr_valid |-> $past(psel && penable && pwrite && paddr == 12'h180
                         && pwdata[0])) else $error("stray command");
   a_busy_gap: assert property (
      mr_valid |=> !mr_valid [*6]) else $error("command too soon");
   a_cs_nonzero: assert property (
      mr_valid |-> mr_chip_selects != 4'h0) else $error("no chip select");
   a_cmd_hold: assert property (
      !mr_valid |-> $stable(mr_payload) && $stable(mr_chip_selects))
      else $error("command fields moved");
   a_rsv_zero: assert property (
      mr_valid |-> mr_payload[31:27] == 5'h00) else $error("reserved set");
   a_busy_read: assert property (
      s_sent |=> prdata[0]) else $error("busy flag low");
   a_ack_read: assert property (
      psel && !penable && !pwrite && paddr == 12'h13c
      && $stable(stacked_refresh_ack_in)
      |=> prdata == $past(stacked_refresh_ack_in)) else $error("ack bad");
   a_cid_read: assert property (
      psel && !penable && !pwrite && paddr == 12'h0e4
      && $stable(stacked_refresh_cid_in)
      |=> prdata[3:1] == $past(stacked_refresh_cid_in)) else $error("cid");
   a_cal_ok: assert property (
      psel && !penable && !pwrite && paddr == 12'h0ec && cal_success
      && $past(cal_success) |=> prdata[0]) else $error("cal flag low");
endmodule

/* dv/dmc_seq_model.sv */
/*
 Memory sequencer model: takes one-cycle commands, reports done.
 Assumes lat is set by the bench before each command.
*/
`timescale 1ns/1ps
module dmc_seq_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [4:0] lat,
   input  wire logic       mr_valid,
   output logic            mr_done
);
   logic [4:0] cnt_reg;
   // Done drops on each command so a slow memory really holds busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 5'h00;
         mr_done <= 1'b1;
      end else if (mr_valid) begin
         cnt_reg <= lat;
         mr_done <= 1'b0;
      end else if (cnt_reg != 5'h00) begin
         cnt_reg <= cnt_reg - 5'h01;
      end else begin
         mr_done <= 1'b1;
      end
   end
endmodule

/* dv/tb_top.sv */
/*
 Bench for the mode-command register bank over APB.
 Assumes zero-wait slave and the sequencer model on the command side.
*/
`timescale 1ns/1ps
module tb_top;
   import dmc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, cal_ok = 1'b0, cal_bad = 1'b0;
   logic pready, pslverr, mr_valid, mr_done, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, ack_in = 32'h0, rd, prdata, mr_payload, pl;
   logic [3:0]  mr_chip_selects, cs, strb = 4'hf;
   logic [2:0]  cid = 3'h0;
   logic [4:0]  lat = 5'h02;
   logic [31:0] mk [3] = '{DMC_MASK_DDR3, DMC_MASK_DDR4, DMC_MASK_LPDDR3};
   logic [3:0]  tbl [4] = '{4'h1, 4'h2, 4'h3, 4'hf};
   int errors = 0, cmp_count = 0, cyc = 0, nval = 0;
   always #20 pclk = ~pclk;
   dmc_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(strb), .prdata, .pready, .pslverr,
      .cal_success(cal_ok), .cal_fail(cal_bad),
      .stacked_refresh_cid_in(cid), .stacked_refresh_ack_in(ack_in),
      .interface_width_in(16'h0040), .toolchain_version_in(16'h0111),
      .mr_valid, .mr_chip_selects, .mr_payload, .mr_done);
   dmc_seq_model u_seq (.pclk, .presetn, .lat, .mr_valid, .mr_done);
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
      if (mr_valid === 1'b1) begin
         nval <= nval + 1;
         cs <= mr_chip_selects;
         pl <= mr_payload;
      end
   end
   task automatic print_verdict();
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic issue(input logic [31:0] c, input logic [1:0] p);
      apb(1'b1, 12'h184, {30'h0, p});
      apb(1'b1, 12'h0dc, c);
      apb(1'b1, 12'h0e0, 32'hffd35a5f);
      apb(1'b1, 12'h180, 32'h1);
   endtask
   task automatic drain();
      apb(1'b0, 12'h0c4, 0);
      for (int t = 0; t < 40 && rd[0] !== 1'b0; t++) apb(1'b0, 12'h0c4, 0);
      chk(rd[0], 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h0ec, 32'h0);
      cal_ok <= 1'b1;
      rdc(12'h0ec, 32'h1);
      {cal_ok, cal_bad} <= 2'b01;
      @(posedge pclk);
      rdc(12'h0ec, 32'h3);
      {cid, ack_in} <= {3'h5, 32'ha5c30f81};
      rdc(12'h0e4, 32'ha);
      rdc(12'h13c, 32'ha5c30f81);
      rdc(12'h110, 32'h40);
      rdc(12'h114, 32'h111);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lat <= (i == 3) ? 5'h14 : 5'h02;
         issue({25'h0, tbl[i], 3'h0}, 2'(i % 3));
         for (int t = 0; t < 4 && nval == i; t++) @(posedge pclk);
         chk(cs, tbl[i]);
         chk(pl, 32'hffd35a5f & mk[i % 3]);
         if (i == 2) chk(pl[19:4], 16'h35a5);
         if (i != 2) chk(pl[20], i != 1);
         rdc(12'h0e0, 32'hffd35a5f);
         apb(1'b0, 12'h0c4, 0);
         chk(rd[0], 1'b1);
         drain();
      end
      strb <= 4'h3;
      apb(1'b1, 12'h0e0, 32'h12345678);
      strb <= 4'hf;
      rdc(12'h0e0, 32'hffd35678);
      for (int k = 0; k < 8; k++) issue((k == 0) ? 0 : 8 + k, 2'h1);
      repeat (4) @(posedge pclk);
      chk(nval, 4);
      rdc(12'h0c4, 32'h2);
      issue(32'h8, 2'h1);
      apb(1'b1, 12'h180, 32'h1);
      drain();
      chk(nval, 5);
      chk(rd[1], 1'b1);
      print_verdict();
   end
endmodule
bind dmc_regs dmc_regs_props u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .stacked_refresh_ack_in,
   .cal_success, .stacked_refresh_cid_in, .mr_valid, .mr_chip_selects,
   .mr_payload);
